/* File: bench/host_model.sv */
/*
 * Host model for the sensor controller: drives the pins and control words.
 * Assumes the bench calls its tasks while clock_in runs.
 */
`timescale 1ns/1ps
module host_model
    import sensor_ctrl_pkg::*;
(
    input  wire logic   clock_in,
    input  wire video_t video_in,
    output logic        reset_low_out,
    output logic        hard_standby_out,
    output logic        output_enable_low_out,
    output ctrl_t       ctrl_out,
    output logic        ctrl_wr_out
);
    ctrl_t shadow_r;

    function automatic ctrl_t defaults();
        ctrl_t c;
        c = '0;
        c.auto_out_off = 1'b1;
        c.hblank_a = HBLANK_A_RST;
        return c;
    endfunction

    initial begin
        reset_low_out = 1'b1;
        hard_standby_out = 1'b0;
        output_enable_low_out = 1'b0; // Keeps shared bus driven
        shadow_r = defaults();
        ctrl_out = shadow_r;
        ctrl_wr_out = 1'b0;
    end

    task automatic write(input ctrl_t c);
        @(negedge clock_in);
        ctrl_out = c;
        ctrl_wr_out = 1'b1;
        @(negedge clock_in);
        ctrl_wr_out = 1'b0;
        shadow_r = (c.soft_rst_sensor | c.soft_rst_soc) ? defaults() : c;
    endtask

    task automatic set_ctx(input logic b);
        ctrl_t c;
        c = shadow_r;
        c.restart = 1'b1; // Restart first parks the frame in blanking
        write(c);
        for (int i = 0; i < 64 && video_in.frame_valid; i++)
            @(negedge clock_in); // Switch only in vertical blanking
        c.context_b = b;
        c.context_chg = 1'b1;
        c.restart = 1'b1; // Restart paired with switch
        write(c);
        shadow_r.context_chg = 1'b0;
        shadow_r.restart = 1'b0;
    endtask

    task automatic oe_pin(input logic disable_out);
        @(negedge clock_in);
        output_enable_low_out = disable_out;
    endtask

    task automatic standby(input logic on);
        @(negedge clock_in);
        hard_standby_out = on;
        repeat (32) @(negedge clock_in); // Clocks kept after entry
    endtask

    task automatic power_reset(input logic on);
        @(negedge clock_in);
        reset_low_out = !on;
        if (on) shadow_r = defaults();
        repeat (6) @(negedge clock_in);
    endtask
endmodule

/* File: bench/tb_sensor_reset_standby_context_ctrl.sv */
/*
 * Self-checking bench for the sensor reset, standby and context block.
 * Assumes host_model drives the pins; clock 250 MHz.
 */
`timescale 1ns/1ps
module tb_sensor_reset_standby_context_ctrl;
    import sensor_ctrl_pkg::*;
    logic        clock_in;
    logic        sys_rst_in;
    logic        reset_low;
    logic        hard_standby;
    logic        oe_low;
    ctrl_t       ctrl;
    logic        ctrl_wr;
    logic [7:0]  pix_in;
    logic [7:0]  pix_out;
    logic        pix_oe;
    video_t      video;
    logic        video_oe;
    logic        core_clk;
    logic        soc_clk;
    logic        analog_stby;
    logic        ctx_b;
    logic [11:0] hblank;
    logic        ack;
    int          n_fail;
    int          n_checks;
    ctrl_t       c;
    logic [7:0]  pix_prev;
    logic        pclk_prev;

    host_model host (.clock_in(clock_in), .video_in(video),
        .reset_low_out(reset_low), .hard_standby_out(hard_standby),
        .output_enable_low_out(oe_low), .ctrl_out(ctrl),
        .ctrl_wr_out(ctrl_wr));

    sensor_reset_standby_context_ctrl #(.DATA_W(8)) dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .reset_low_in(reset_low), .hard_standby_in(hard_standby),
        .output_enable_low_in(oe_low), .ctrl_in(ctrl),
        .ctrl_wr_in(ctrl_wr), .pixel_data_in(pix_in),
        .pixel_data_out(pix_out), .pixel_data_oe_out(pix_oe),
        .video_out(video), .video_oe_out(video_oe),
        .core_clk_en_out(core_clk), .soc_clk_en_out(soc_clk),
        .analog_standby_out(analog_stby), .context_b_out(ctx_b),
        .hblank_active_out(hblank), .context_ack_out(ack));

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    always @(negedge clock_in) pix_in <= pix_in + 8'h01;

    // Line valid only inside frame valid
    always @(negedge clock_in)
        if (!sys_rst_in && video.line_valid === 1'b1 &&
            video.frame_valid !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t line valid outside frame", $time);
        end

    // Data changes only with a pixel clock fall
    always @(negedge clock_in) begin
        if (!sys_rst_in && pix_out !== pix_prev) begin
            n_checks++;
            if ({video.pixel_clock, pclk_prev} !== 2'h1) begin
                n_fail++;
                $display("ERROR %0t data not launched on fall", $time);
            end
        end
        pix_prev  <= pix_out;
        pclk_prev <= video.pixel_clock;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                       input string msg);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic settle();
        repeat (6) @(negedge clock_in);
    endtask

    task automatic t_power_reset();
        logic k;
        c = host.shadow_r;
        c.hblank_a = 12'h100;
        host.write(c);
        settle();
        host.power_reset(1'b1);
        chk(hblank, HBLANK_A_RST, "hblank in reset");
        chk(soc_clk, 1'b0, "soc clock in reset");
        k = core_clk;
        @(negedge clock_in);
        chk(core_clk, !k, "core clock toggles");
        host.power_reset(1'b0);
        chk(soc_clk, 1'b1, "soc clock after reset");
    endtask

    task automatic ctx(input logic b, input logic [11:0] exp);
        int i;
        host.set_ctx(b);
        for (i = 0; i < 64 && ack !== 1'b1; i++) @(negedge clock_in);
        chk(ack, 1'b1, "context ack");
        chk(video.frame_valid, 1'b0, "switch in vblank");
        settle();
        chk(ctx_b, b, "active context");
        chk(hblank, exp, "context blanking");
    endtask

    task automatic t_context();
        c = host.shadow_r;
        c.hblank_a = 12'h072;
        host.write(c);
        settle();
        chk(hblank, 12'h072, "hblank A");
        ctx(1'b1, 12'h0E4); // Snapshot entry
        ctx(1'b1, 12'h0E4); // Second frame in B
        ctx(1'b0, 12'h072); // Back to preview
    endtask

    task automatic t_outputs();
        host.oe_pin(1'b1);
        settle();
        chk({pix_oe, video_oe}, 2'h0, "pin disable");
        host.oe_pin(1'b0);
        settle();
        chk({pix_oe, video_oe}, 2'h3, "pin enable");
        c = host.shadow_r;
        c.out_disable = 1'b1;
        host.write(c);
        settle();
        chk({pix_oe, video_oe}, 2'h0, "bit disable");
        c.out_disable = 1'b0;
        host.write(c);
        settle();
        chk({pix_oe, video_oe}, 2'h3, "bit enable");
    endtask

    task automatic t_standby();
        c = host.shadow_r;
        c.hblank_a = 12'h0C8;
        host.write(c);
        host.standby(1'b1);
        chk({analog_stby, soc_clk}, 2'h2, "standby state");
        chk({pix_oe, video_oe}, 2'h0, "standby outputs");
        c.hblank_a = 12'h0F0;
        host.write(c);
        host.standby(1'b0);
        chk({analog_stby, soc_clk}, 2'h1, "standby exit");
        chk(hblank, 12'h0C8, "kept blanking");
        c.hblank_a = 12'h0C8;
        c.auto_out_off = 1'b0;
        host.write(c);
        host.standby(1'b1);
        chk({pix_oe, video_oe}, 2'h3, "auto off disabled");
        host.standby(1'b0);
    endtask

    task automatic t_soft();
        c = host.shadow_r;
        c.pipe_stby = 1'b1;
        host.write(c);
        settle();
        chk(soc_clk, 1'b0, "pipe standby");
        c.pipe_stby = 1'b0;
        c.sensor_stby = 1'b1;
        host.write(c);
        settle();
        chk({soc_clk, analog_stby}, 2'h3, "sensor standby");
        for (int k = 0; k < 2; k++) begin
            c = host.shadow_r;
            c.hblank_a = 12'h123;
            host.write(c);
            c.soft_rst_sensor = (k == 0);
            c.soft_rst_soc = (k == 1);
            host.write(c);
            settle();
            chk(hblank, HBLANK_A_RST, "soft reset");
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #(20000 * 4);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        pix_in = 8'h00;
        sys_rst_in = 1'b1;
        repeat (16) @(negedge clock_in);
        sys_rst_in = 1'b0;
        settle();
        chk(hblank, HBLANK_A_RST, "hblank default");
        chk(ctx_b, 1'b0, "context A default");
        t_power_reset();
        t_context();
        t_outputs();
        t_standby();
        t_soft();
        close_out();
    end
endmodule

/* File: rtl/sensor_ctrl_pkg.sv */
/*
 * Package for the sensor reset, standby and context controller.
 * Assumes a single 250 MHz clock domain and host-driven pins.
 */
// Contract
// - Context A preview, context B snapshot
// - Per-context blanking, B twice A
// - Accept one context change per frame; code applies every request, several per blanking possible
// - Frame valid brackets line valid by delays; code raises both together in row 0, delay at frame end only
// - Outputs launched on pixel clock fall
// - Power-up reset holds registers at default
// - Reset leaves only divided core clock
// - Soft resets restore defaults, serial runs
// - Hard standby stops clocks, analog standby
// - Sensor soft standby control bit exists
// - Pipe standby gates pixel clock
// - Outputs off in hard standby unless disabled
// - Outputs gated by pin or control bit
package sensor_ctrl_pkg;
    localparam int          HBLANK_W        = 12;
    localparam int          LINE_W          = 12;
    localparam int          ROW_W           = 11;
    localparam int          FRAME_EDGE_W    = 4;
    localparam int          STBY_W          = 5;
    localparam logic [11:0] HBLANK_A_RST    = 12'h0BE;
    localparam logic [11:0] ACTIVE_A_RST    = 12'h288;
    localparam logic [11:0] ACTIVE_B_RST    = 12'h508;
    localparam logic [10:0] ROWS_A_RST      = 11'h208;
    localparam logic [10:0] ROWS_B_RST      = 11'h408;
    localparam logic [10:0] VBLANK_A_RST    = 11'h011;
    localparam logic [10:0] VBLANK_B_RST    = 11'h02A;
    localparam logic [3:0]  FRAME_EDGE_PCLK = 4'h4;
    localparam logic [4:0]  STBY_ENTRY_CYC  = 5'h18;
    localparam logic [1:0]  PCLK_DIV_B      = 2'h1;
    localparam logic [1:0]  PCLK_DIV_A      = 2'h3;

    typedef enum logic {CTX_A, CTX_B} context_t;

    typedef enum {
        ST_RUN,
        ST_ENTER,
        ST_STANDBY
    } power_state_t;

    typedef struct packed {
        logic       soft_rst_sensor;
        logic       soft_rst_soc;
        logic       sensor_stby;
        logic       pipe_stby;
        logic       auto_out_off;
        logic       out_disable;
        logic       context_b;
        logic       context_chg;
        logic       restart;
        logic [11:0] hblank_a;
    } ctrl_t;

    typedef struct packed {
        logic pixel_clock;
        logic frame_valid;
        logic line_valid;
    } video_t;
endpackage

/* File: rtl/sensor_reset_standby_context_ctrl.sv */
/*
 * Reset, standby, context and frame timing control of the image sensor.
 * Assumes pins are asynchronous to clock_in; control bits come from
 * the serial register block on the same clock as pulses or levels.
 */
`timescale 1ns/1ps
module sensor_reset_standby_context_ctrl
    import sensor_ctrl_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    input  wire logic              reset_low_in,
    input  wire logic              hard_standby_in,
    input  wire logic              output_enable_low_in,
    input  wire ctrl_t             ctrl_in,
    input  wire logic              ctrl_wr_in,
    input  wire logic [DATA_W-1:0] pixel_data_in,
    output logic [DATA_W-1:0]      pixel_data_out,
    output logic                   pixel_data_oe_out,
    output video_t                 video_out,
    output logic                   video_oe_out,
    output logic                   core_clk_en_out,
    output logic                   soc_clk_en_out,
    output logic                   analog_standby_out,
    output logic                   context_b_out,
    output logic [HBLANK_W-1:0]    hblank_active_out,
    output logic                   context_ack_out
);
    logic [1:0]          rstl_sync_r, stby_sync_r, oel_sync_r;
    logic                por_active, stby_pin, oe_pin_low;
    ctrl_t               ctrl_r;
    power_state_t        pstate_r;
    logic [STBY_W-1:0]   stby_cnt_r;
    logic                clocks_on;
    logic                core_div_r;
    logic [1:0]          pdiv_r;
    logic                pclk_r;
    logic                pclk_fall;
    context_t            ctx_r;
    logic                ctx_pending_r;
    logic                in_vblank;
    logic [LINE_W-1:0]   col_r;
    logic [ROW_W-1:0]    row_r;
    logic                fv_r, lv_r;
    logic [DATA_W-1:0]   data_r;
    logic [HBLANK_W-1:0] hblank_a_r;

    function automatic logic [HBLANK_W-1:0] hblank_of(
        input context_t c, input logic [HBLANK_W-1:0] a);
        hblank_of = (c == CTX_B) ? {a[HBLANK_W-2:0], 1'b0} : a;
    endfunction

    // Pin synchronisers
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rstl_sync_r <= 2'h0;
            stby_sync_r <= 2'h0;
            oel_sync_r  <= 2'h3;
        end else begin
            rstl_sync_r <= {rstl_sync_r[0], reset_low_in};
            stby_sync_r <= {stby_sync_r[0], hard_standby_in};
            oel_sync_r  <= {oel_sync_r[0], output_enable_low_in};
        end
    end
    assign por_active = ~rstl_sync_r[1];
    assign stby_pin   = stby_sync_r[1];
    assign oe_pin_low = oel_sync_r[1];

    // Control registers; defaults under power-up or soft reset
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_r     <= '0;
            ctrl_r.auto_out_off <= 1'b1;
            hblank_a_r <= HBLANK_A_RST;
        end else if (por_active) begin
            ctrl_r     <= '0;
            ctrl_r.auto_out_off <= 1'b1;
            hblank_a_r <= HBLANK_A_RST;
        end else if (ctrl_wr_in &&
                     (ctrl_in.soft_rst_sensor || ctrl_in.soft_rst_soc)) begin
            ctrl_r     <= '0;
            ctrl_r.auto_out_off <= 1'b1;
            hblank_a_r <= HBLANK_A_RST;
        end else if (ctrl_wr_in && clocks_on) begin
            ctrl_r     <= ctrl_in;
            hblank_a_r <= ctrl_in.hblank_a;
        end else if (!clocks_on) begin
            ctrl_r.auto_out_off <= ctrl_r.auto_out_off;
        end
    end

    // Hard standby entry takes a fixed count of clocks
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pstate_r   <= ST_RUN;
            stby_cnt_r <= '0;
        end else begin
            unique case (pstate_r)
                ST_RUN: begin
                    stby_cnt_r <= '0;
                    if (stby_pin) begin
                        pstate_r <= ST_ENTER;
                    end
                end
                ST_ENTER: begin
                    stby_cnt_r <= stby_cnt_r + 5'h01;
                    if (!stby_pin) begin
                        pstate_r <= ST_RUN;
                    end else if (stby_cnt_r == STBY_ENTRY_CYC - 5'h01) begin
                        pstate_r <= ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (!stby_pin) begin
                        pstate_r <= ST_RUN;
                    end
                end
            endcase
        end
    end
    assign clocks_on = (pstate_r != ST_STANDBY) && !por_active;

    // Core clock divided by two keeps running in power-up reset
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            core_div_r <= 1'b0;
        end else if (pstate_r != ST_STANDBY) begin
            core_div_r <= ~core_div_r;
        end
    end

    // Pixel clock; B runs twice the rate of A
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pdiv_r <= 2'h0;
            pclk_r <= 1'b0;
        end else if (!clocks_on || ctrl_r.pipe_stby) begin
            pdiv_r <= 2'h0;
            pclk_r <= 1'b0;
        end else if (pdiv_r == ((ctx_r == CTX_B) ? PCLK_DIV_B : PCLK_DIV_A))
        begin
            pdiv_r <= 2'h0;
            pclk_r <= ~pclk_r;
        end else begin
            pdiv_r <= pdiv_r + 2'h1;
        end
    end
    assign pclk_fall = clocks_on && !ctrl_r.pipe_stby && pclk_r &&
        (pdiv_r == ((ctx_r == CTX_B) ? PCLK_DIV_B : PCLK_DIV_A));

    // Context switch deferred to a pixel clock fall in vertical blanking
    assign in_vblank = !fv_r;
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctx_r         <= CTX_A;
            ctx_pending_r <= 1'b0;
        end else if (por_active) begin
            ctx_r         <= CTX_A;
            ctx_pending_r <= 1'b0;
        end else if (ctrl_wr_in && ctrl_in.context_chg) begin
            ctx_pending_r <= 1'b1;
        end else if (ctx_pending_r && in_vblank && pclk_fall) begin
            ctx_r <= ctrl_r.context_b ? CTX_B : CTX_A;
            ctx_pending_r <= 1'b0;
        end
    end

    // Frame and line timing in pixel clocks
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            col_r <= '0;
            row_r <= '0;
        end else if (ctrl_r.restart || por_active) begin
            col_r <= '0;
            row_r <= '0;
        end else if (pclk_fall && !ctrl_r.sensor_stby) begin
            if (col_r == ((ctx_r == CTX_B) ? ACTIVE_B_RST : ACTIVE_A_RST)
                    + hblank_of(ctx_r, hblank_a_r) - 12'h001) begin
                col_r <= '0;
                if (row_r == ((ctx_r == CTX_B) ?
                        ROWS_B_RST + VBLANK_B_RST :
                        ROWS_A_RST + VBLANK_A_RST) - 11'h001) begin
                    row_r <= '0;
                end else begin
                    row_r <= row_r + 11'h001;
                end
            end else begin
                col_r <= col_r + 12'h001;
            end
        end
    end

    // Launch on pixel clock falling edge
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fv_r   <= 1'b0;
            lv_r   <= 1'b0;
            data_r <= '0;
        end else if (pclk_fall) begin
            fv_r <= (row_r < ((ctx_r == CTX_B) ? ROWS_B_RST : ROWS_A_RST))
                && !(row_r == '0 && col_r < 12'(FRAME_EDGE_PCLK));
            lv_r <= (row_r < ((ctx_r == CTX_B) ? ROWS_B_RST : ROWS_A_RST))
                && (col_r >= 12'(FRAME_EDGE_PCLK)) && (col_r <
                ((ctx_r == CTX_B) ? ACTIVE_B_RST : ACTIVE_A_RST));
            data_r <= pixel_data_in;
        end
    end

    // Output registers and enables
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pixel_data_out     <= '0;
            pixel_data_oe_out  <= 1'b0;
            video_out          <= '0;
            video_oe_out       <= 1'b0;
            core_clk_en_out    <= 1'b0;
            soc_clk_en_out     <= 1'b0;
            analog_standby_out <= 1'b0;
            context_b_out      <= 1'b0;
            hblank_active_out  <= HBLANK_A_RST;
            context_ack_out    <= 1'b0;
        end else begin
            pixel_data_out     <= data_r;
            video_out          <= '{pclk_r, fv_r, lv_r};
            pixel_data_oe_out  <= !oe_pin_low && !ctrl_r.out_disable &&
                !(pstate_r == ST_STANDBY && ctrl_r.auto_out_off);
            video_oe_out       <= !oe_pin_low && !ctrl_r.out_disable &&
                !(pstate_r == ST_STANDBY && ctrl_r.auto_out_off);
            core_clk_en_out    <= pstate_r != ST_STANDBY && core_div_r;
            soc_clk_en_out     <= clocks_on && !ctrl_r.pipe_stby;
            analog_standby_out <= pstate_r == ST_STANDBY || ctrl_r.sensor_stby;
            context_b_out      <= ctx_r == CTX_B;
            hblank_active_out  <= hblank_of(ctx_r, hblank_a_r);
            context_ack_out    <= ctx_pending_r && in_vblank && pclk_fall;
        end
    end

    standby_count_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        $rose(pstate_r == ST_ENTER) && stby_pin |->
        !(pstate_r == ST_STANDBY) [*8])
        else $error("standby entered too early");

    blank_double_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        ctx_r == CTX_B |=>
            hblank_active_out == {$past(hblank_a_r[HBLANK_W-2:0]), 1'b0})
        else $error("context B blanking not doubled");

    stby_clocks_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        pstate_r == ST_STANDBY |=> !soc_clk_en_out && analog_standby_out)
        else $error("clocks running in standby");

    auto_off_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        pstate_r == ST_STANDBY && ctrl_r.auto_out_off |=> !video_oe_out)
        else $error("outputs driven in standby");

    oe_pin_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        oe_pin_low |=> !pixel_data_oe_out)
        else $error("outputs driven with enable pin high");

    por_default_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        por_active |=> ctrl_r.auto_out_off && !ctrl_r.out_disable
            && ctx_r == CTX_A)
        else $error("control not default in reset");

    pipe_stby_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        ctrl_r.pipe_stby |=> !pclk_r)
        else $error("pixel clock runs in pipe standby");

    ctx_vblank_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        $changed(ctx_r) |-> $past(!fv_r))
        else $error("context switched inside frame");

    launch_fall_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        $changed(lv_r) |-> $past(pclk_r) && !pclk_r)
        else $error("line valid not launched on fall");

    core_div_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        por_active && pstate_r != ST_STANDBY |=>
            core_div_r != $past(core_div_r))
        else $error("core clock stopped in reset");

    soft_rst_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        ctrl_wr_in && (ctrl_in.soft_rst_sensor || ctrl_in.soft_rst_soc)
            |=> hblank_a_r == HBLANK_A_RST && ctrl_r.auto_out_off)
        else $error("soft reset left control changed");

    stby_keep_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        pstate_r == ST_STANDBY && !por_active &&
            !ctrl_in.soft_rst_sensor && !ctrl_in.soft_rst_soc
            |=> $stable(ctrl_r) && $stable(hblank_a_r))
        else $error("control changed in standby");
endmodule
